// [rtl/node_setup_pkg.sv]
// shared constants for the bus node setup and positioning loop block
// assumes a 100 MHz system clock and a 32-bit apb register bus
package node_setup_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_NODE_ADDR = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_TARGET = 8'h0c;
    localparam logic [7:0] OFF_ACTUAL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_NET = 8'h18;
    localparam logic [7:0] OFF_FEATURES = 8'h1c;
    localparam logic [7:0] OFF_ENCODER = 8'h20;
    // control register field positions
    localparam int CTRL_LOOP_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_HEARTBEAT_BIT = 2;
    localparam int CTRL_LEARNED_BIT = 3;
    // network status register field positions
    localparam int NET_BUS_BIT = 0;
    localparam int NET_UCMM_BIT = 1;
    localparam int NET_MINOR_BIT = 2;
    localparam int NET_MAJOR_BIT = 3;
    localparam int NET_COMMERR_BIT = 4;
    // status word bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REACHED_BIT = 1;
    localparam int STAT_ERROR_BIT = 9;
    // node address handling
    localparam logic [6:0] SWITCH_BUS_LOW = 7'd64;
    localparam logic [6:0] SWITCH_BUS_HIGH = 7'd99;
    localparam logic [5:0] NODE_ADDR_RESET = 6'h3f;
    localparam int NODE_ADDR_ATTR = 38;
    // bit rate codes in kbaud
    localparam logic [9:0] RATE_125 = 10'd125;
    localparam logic [9:0] RATE_250 = 10'd250;
    localparam logic [9:0] RATE_500 = 10'd500;
    // fixed messaging features
    localparam logic [3:0] EXPLICIT_CONNS = 4'h2;
    localparam logic [3:0] FIXED_ASSEMBLIES = 4'h4;
    localparam int FEAT_POLL_BIT = 8;
    localparam int FEAT_STROBE_BIT = 9;
    localparam int FEAT_COS_BIT = 10;
    localparam int FEAT_MCAST_BIT = 11;
    // loop overshoot of 5/8 turn in encoder increments
    localparam int INCR_PER_TURN = 1024;
    localparam int LOOP_OVERSHOOT = INCR_PER_TURN * 5 / 8;
    // led flash timebase: one second period, half on, half off
    localparam int CLK_HZ = 100_000_000;
    localparam int FLASH_PERIOD_MS = 1000;
    localparam int FLASH_HALF_CYCLES = CLK_HZ / 1000 * FLASH_PERIOD_MS / 2;
endpackage

// [rtl/flash_timebase.sv]
// divided timebase giving a square wave with equal on and off phases
// assumes one clock domain; half period set by the parent
`timescale 1ns/10ps
module flash_timebase #(
    parameter int HALF_CYCLES = 50_000_000
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic phase
);
    typedef struct packed {
        logic [31:0] count;
        logic phase;
    } tb_state_t;
    tb_state_t s_q, s_d;

    initial begin
        if (HALF_CYCLES < 1) begin
            $error("flash half period must be at least one cycle");
        end
    end

    // count one half period, then toggle the phase
    always_comb begin
        s_d = s_q;
        if (s_q.count >= 32'(HALF_CYCLES - 1)) begin
            s_d.count = 32'h0;
            s_d.phase = ~s_q.phase;
        end else begin
            s_d.count = s_q.count + 32'h1;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign phase = s_q.phase;
endmodule // flash_timebase

// [rtl/bus_node_setup.sv]
// bus node setup, bit rate select, positioning loop sequencer and status leds
// assumes an apb master, a motion core that follows moveTarget, and an encoder reading
// How it works
// - node address is tens switch times ten plus ones
// - switch 64..99 uses bus-written address attribute
// - factory switch 99 gives address 63
// - switch below 64 rejects bus address writes
// - slide switch selects bit rate per variant
// - capless variant takes address and rate from bus
// - loop mode: larger target driven straight forward
// - loop mode: smaller target overshoots 5/8 back
// - after loopless reverse, next approach ends forward
// - encoder mismatch on arrival sets status bit 9
// - no-loop mode drives directly, except a reverse right after a loopless reverse
// - exactly two explicit connections offered
// - four fixed-mapping assemblies offered
// - poll, strobe, cos/cyclic; no multicast poll
// - heartbeat off after reset until enabled
// - net led dark without bus, green when operational
// - green flash without ucmm link or learning run
// - red flash for minor fault
// - steady red for major fault
// - red-green alternate flash for communication error
// - yellow led follows motor supply presence
`timescale 1ns/10ps
module bus_node_setup
    import node_setup_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYCLES,
    parameter bit RATE_VARIANT = 1'b0,
    parameter bit HAS_SWITCH_CAP = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] switchTens,
    input wire logic [3:0] switchOnes,
    input wire logic [1:0] rateSwitch,
    input wire logic motorSupplyOk,
    input wire logic moveDone,
    input wire logic [31:0] encoderPos,
    output logic [31:0] moveTarget,
    output logic moveGo,
    output logic [5:0] nodeAddr,
    output logic [9:0] bitRate,
    output logic heartbeatEn,
    output logic ledGreen,
    output logic ledRed,
    output logic ledYellow
);
    // approach sequencer states
    typedef enum logic [1:0] {
        IDLE,
        DRIVE,
        FINISH,
        CHECK
    } move_state_t;

    // the whole state of the block apart from the flash timebase; every output is one field of it
    typedef struct packed {
        move_state_t mv;
        logic loopMode;
        logic heartbeat;
        logic learned;
        logic [5:0] busAddr;
        logic [9:0] busRate;
        logic [31:0] target;
        logic [31:0] actual;
        logic lastReverse;
        logic busy;
        logic reached;
        logic posError;
        logic [4:0] net;
        logic [31:0] cmd;
        logic go;
        logic [5:0] addr;
        logic [9:0] rate;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic green;
        logic red;
        logic yellow;
    } node_state_t;

    node_state_t s_q, s_d;
    logic flash;
    logic [6:0] switchVal;
    logic [9:0] switchRate;
    logic useBusAddr;
    logic setupPhase;
    logic accessWrite;
    logic [31:0] features;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic netBus;
    logic netUcmm;
    logic netMinor;
    logic netMajor;
    logic netCommErr;
    logic goingBack;
    logic needLoop;

    // parameter checks: the logic cannot serve these settings
    initial begin
        if (FLASH_HALF < 1) begin
            $error("flash half period must be positive");
        end
        if (LOOP_OVERSHOOT < 1 || LOOP_OVERSHOOT >= INCR_PER_TURN) begin
            $error("loop overshoot must be a part of one turn");
        end
        if (SWITCH_BUS_HIGH < SWITCH_BUS_LOW) begin
            $error("bus address switch range is empty");
        end
    end

    flash_timebase #(
        .HALF_CYCLES(FLASH_HALF)
    ) u_timebase (
        .ref_clk(ref_clk),
        .rst(rst),
        .phase(flash)
    );

    // decimal switch value and bit rate decode
    always_comb begin
        switchVal = 7'(switchTens) * 7'd10 + 7'(switchOnes);
        useBusAddr = !HAS_SWITCH_CAP || (switchVal >= SWITCH_BUS_LOW && switchVal <= SWITCH_BUS_HIGH);
        case (rateSwitch)
            2'b00: switchRate = RATE_125;
            2'b01: switchRate = RATE_VARIANT ? RATE_250 : RATE_500;
            2'b10: switchRate = RATE_VARIANT ? RATE_500 : RATE_250;
            default: switchRate = s_q.busRate;
        endcase
        if (!HAS_SWITCH_CAP) begin
            switchRate = s_q.busRate;
        end
    end

    // fixed messaging feature word
    always_comb begin
        features = 32'h0;
        features[3:0] = EXPLICIT_CONNS;
        features[7:4] = FIXED_ASSEMBLIES;
        features[FEAT_POLL_BIT] = 1'b1;
        features[FEAT_STROBE_BIT] = 1'b1;
        features[FEAT_COS_BIT] = 1'b1;
        features[FEAT_MCAST_BIT] = 1'b0;
    end

    // control readback; start is a strobe and always reads as zero
    always_comb begin
        ctrlWord = 32'h0;
        ctrlWord[CTRL_LOOP_BIT] = s_q.loopMode;
        ctrlWord[CTRL_START_BIT] = 1'b0;
        ctrlWord[CTRL_HEARTBEAT_BIT] = s_q.heartbeat;
        ctrlWord[CTRL_LEARNED_BIT] = s_q.learned;
    end

    // status word; the error bit holds until the next start
    always_comb begin
        statusWord = 32'h0;
        statusWord[STAT_BUSY_BIT] = s_q.busy;
        statusWord[STAT_REACHED_BIT] = s_q.reached;
        statusWord[STAT_ERROR_BIT] = s_q.posError;
    end

    // network status fields as last written by the bus side
    assign netBus = s_q.net[NET_BUS_BIT];
    assign netUcmm = s_q.net[NET_UCMM_BIT];
    assign netMinor = s_q.net[NET_MINOR_BIT];
    assign netMajor = s_q.net[NET_MAJOR_BIT];
    assign netCommErr = s_q.net[NET_COMMERR_BIT];

    // approach direction; the loop is due on a reverse in loop mode or after a loopless reverse
    assign goingBack = $signed(s_q.target) < $signed(s_q.actual);
    assign needLoop = goingBack && (pwdata[CTRL_LOOP_BIT] || s_q.lastReverse);

    // apb phase decode; a write lands on the edge that samples pready high
    assign setupPhase = psel && !penable;
    assign accessWrite = psel && penable && pwrite && s_q.ready;

    // next state: bus slave, sequencer, leds
    always_comb begin
        s_d = s_q;
        s_d.go = 1'b0;
        // apb: no wait state, ready in the first access cycle
        s_d.ready = setupPhase;
        s_d.err = 1'b0;
        if (setupPhase) begin
            case (paddr)
                OFF_CTRL: s_d.rdata = ctrlWord;
                OFF_NODE_ADDR: s_d.rdata = {26'h0, s_q.addr};
                OFF_RATE: s_d.rdata = {22'h0, s_q.rate};
                OFF_TARGET: s_d.rdata = s_q.target;
                OFF_ACTUAL: s_d.rdata = s_q.actual;
                OFF_STATUS: s_d.rdata = statusWord;
                OFF_NET: s_d.rdata = {27'h0, s_q.net};
                OFF_FEATURES: s_d.rdata = features;
                OFF_ENCODER: s_d.rdata = encoderPos;
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.err = 1'b1;
                end
            endcase
            if (pwrite) begin
                s_d.rdata = 32'h0;
                // node address write is refused while the switches select it
                if (paddr == OFF_NODE_ADDR && !useBusAddr) begin
                    s_d.err = 1'b1;
                end
            end
        end
        // register writes; a refused transfer changes nothing
        if (accessWrite && !s_q.err) begin
            case (paddr)
                OFF_CTRL: begin
                    s_d.loopMode = pwdata[CTRL_LOOP_BIT];
                    s_d.heartbeat = pwdata[CTRL_HEARTBEAT_BIT];
                    s_d.learned = pwdata[CTRL_LEARNED_BIT];
                    if (pwdata[CTRL_START_BIT] && s_q.mv == IDLE) begin
                        s_d.mv = DRIVE;
                        s_d.busy = 1'b1;
                        s_d.reached = 1'b0;
                        s_d.posError = 1'b0;
                        s_d.go = 1'b1;
                        // choose first leg of the approach
                        if (!goingBack) begin
                            s_d.cmd = s_q.target;
                            s_d.lastReverse = 1'b0;
                        end else if (needLoop) begin
                            s_d.cmd = s_q.target - 32'(LOOP_OVERSHOOT);
                        end else begin
                            s_d.cmd = s_q.target;
                            s_d.lastReverse = 1'b1;
                        end
                    end
                end
                OFF_NODE_ADDR: s_d.busAddr = pwdata[5:0];
                OFF_RATE: s_d.busRate = pwdata[9:0];
                OFF_TARGET: s_d.target = pwdata;
                OFF_ACTUAL: s_d.actual = pwdata;
                OFF_NET: s_d.net = pwdata[4:0];
                default: s_d.net = s_q.net;
            endcase
        end
        // approach sequencer
        case (s_q.mv)
            IDLE: s_d.mv = s_d.mv;
            DRIVE: begin
                if (moveDone) begin
                    s_d.actual = s_q.cmd;
                    if (s_q.cmd != s_q.target) begin
                        s_d.mv = FINISH;
                        s_d.cmd = s_q.target;
                        s_d.go = 1'b1;
                        s_d.lastReverse = 1'b0;
                    end else begin
                        s_d.mv = CHECK;
                    end
                end
            end
            FINISH: begin
                if (moveDone) begin
                    s_d.actual = s_q.target;
                    s_d.mv = CHECK;
                end
            end
            CHECK: begin
                s_d.mv = IDLE;
                s_d.busy = 1'b0;
                s_d.reached = 1'b1;
                if (encoderPos != s_q.target) begin
                    s_d.posError = 1'b1;
                end
            end
            default: s_d.mv = IDLE;
        endcase
        // node address and rate outputs
        if (useBusAddr) begin
            s_d.addr = s_q.busAddr;
        end else begin
            s_d.addr = switchVal[5:0];
        end
        // bit rate follows the decoded slide switch, or the bus-written rate in the capless variant
        s_d.rate = switchRate;
        // network led priority: no bus, major, comm error, minor, not ready, ok
        if (!netBus) begin
            s_d.green = 1'b0;
            s_d.red = 1'b0;
        end else if (netMajor) begin
            s_d.green = 1'b0;
            s_d.red = 1'b1;
        end else if (netCommErr) begin
            s_d.green = flash;
            s_d.red = ~flash;
        end else if (netMinor) begin
            s_d.green = 1'b0;
            s_d.red = flash;
        end else if (!netUcmm || !s_q.learned) begin
            s_d.green = flash;
            s_d.red = 1'b0;
        end else begin
            s_d.green = 1'b1;
            s_d.red = 1'b0;
        end
        s_d.yellow = motorSupplyOk;
    end

    // state register with reset values
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.mv <= IDLE;
            s_q.busAddr <= NODE_ADDR_RESET;
            s_q.addr <= NODE_ADDR_RESET;
            s_q.busRate <= RATE_125;
            s_q.rate <= RATE_125;
            s_q.heartbeat <= 1'b0;
            s_q.loopMode <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err; // err is only ever set together with ready
    assign moveTarget = s_q.cmd;
    assign moveGo = s_q.go;
    assign nodeAddr = s_q.addr;
    assign bitRate = s_q.rate;
    assign heartbeatEn = s_q.heartbeat;
    assign ledGreen = s_q.green;
    assign ledRed = s_q.red;
    assign ledYellow = s_q.yellow;
endmodule // bus_node_setup

// [sim/node_setup_sva.sv]
// concurrent checks on the node setup block ports
// assumes one clock domain and the package constants
`timescale 1ns/10ps
module node_setup_sva
    import node_setup_pkg::*;
#(
    parameter bit HAS_SWITCH_CAP = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] switchTens,
    input wire logic [3:0] switchOnes,
    input wire logic [1:0] rateSwitch,
    input wire logic motorSupplyOk,
    input wire logic moveDone,
    input wire logic moveGo,
    input wire logic [5:0] nodeAddr,
    input wire logic [9:0] bitRate,
    input wire logic heartbeatEn,
    input wire logic ledGreen,
    input wire logic ledRed,
    input wire logic ledYellow
);
    logic [6:0] swVal;
    logic ctrlAcc;
    logic [4:0] netQ;
    // decimal switch value and control write decode
    assign swVal = 7'(switchTens) * 7'd10 + 7'(switchOnes);
    assign ctrlAcc = psel && penable && pwrite && paddr == OFF_CTRL;
    // shadow of the network status register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            netQ <= 5'h00;
        end else if (psel && penable && pready && pwrite && paddr == OFF_NET) begin
            netQ <= pwdata[4:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence addr_write_s;
        HAS_SWITCH_CAP && psel && penable && pwrite && paddr == OFF_NODE_ADDR && swVal < SWITCH_BUS_LOW;
    endsequence
    apb_answer_a: assert property (setup_s |=> pready && penable)
        else $error("access phase not answered at once");
    node_switch_a: assert property (HAS_SWITCH_CAP && swVal < SWITCH_BUS_LOW |=> nodeAddr == $past(swVal[5:0]))
        else $error("node address not taken from switches");
    node_refuse_a: assert property (addr_write_s |-> pslverr)
        else $error("address write accepted under switch control");
    rate_base_a: assert property (HAS_SWITCH_CAP && rateSwitch == 2'b00 |=> bitRate == RATE_125)
        else $error("slow bit rate not selected");
    heartbeat_cause_a: assert property ($rose(heartbeatEn) |-> $past(ctrlAcc && pwdata[CTRL_HEARTBEAT_BIT]))
        else $error("heartbeat enabled without a write");
    move_pulse_a: assert property (moveGo |=> !moveGo)
        else $error("leg start longer than one cycle");
    move_cause_a: assert property (moveGo |-> $past(ctrlAcc && pwdata[CTRL_START_BIT]) || $past(moveDone) ||
        $past(moveDone, 2))
        else $error("leg started without start or arrival");
    supply_led_a: assert property (1'b1 |=> ledYellow == $past(motorSupplyOk))
        else $error("yellow led does not follow supply");
    led_dark_a: assert property (!netQ[NET_BUS_BIT] |=> !ledGreen && !ledRed)
        else $error("network led lit without bus");
    led_major_a: assert property (netQ[NET_BUS_BIT] && netQ[NET_MAJOR_BIT] |=> ledRed && !ledGreen)
        else $error("major fault not steady red");
endmodule // node_setup_sva
bind bus_node_setup node_setup_sva #(.HAS_SWITCH_CAP(HAS_SWITCH_CAP)) i_sva (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .switchTens, .switchOnes, .rateSwitch, .motorSupplyOk,
    .moveDone, .moveGo, .nodeAddr, .bitRate, .heartbeatEn, .ledGreen, .ledRed, .ledYellow);

// [sim/motion_core_model.sv]
// behavioural motion core that answers each leg after a set delay
// assumes moveGo is a one-cycle pulse with moveTarget valid
`timescale 1ns/10ps
module motion_core_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic moveGo,
    input wire logic [31:0] moveTarget,
    input wire logic [3:0] legDelay,
    input wire logic [31:0] encSkew,
    output logic moveDone,
    output logic [31:0] encoderPos
);
    logic [31:0] goal;
    logic [3:0] cnt;
    // count the leg down, then report arrival and the reached position
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            goal <= 32'h0;
            moveDone <= 1'b0;
            encoderPos <= 32'h0;
        end else begin
            moveDone <= 1'b0;
            if (moveGo) begin
                goal <= moveTarget;
                cnt <= legDelay;
            end else if (cnt == 4'h1) begin
                // every leg ends at its goal, never against a stop, so no torque limit is asked for
                moveDone <= 1'b1;
                encoderPos <= goal + encSkew; // skew only when a scenario asks for a bad reading
                cnt <= 4'h0;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule // motion_core_model

// [sim/bus_node_setup_tb.sv]
// self-checking bench for the node setup block
// assumes the motion core model on the leg interface
`timescale 1ns/10ps
module bus_node_setup_tb;
    import node_setup_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, motorSupplyOk, moveDone, moveGo, errv;
    logic heartbeatEn, ledGreen, ledRed, ledYellow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, encoderPos, moveTarget, encSkew, rdv;
    logic [3:0] switchTens, switchOnes, legDelay;
    logic [1:0] rateSwitch;
    logic [5:0] nodeAddr;
    logic [9:0] bitRate;
    logic [31:0] legs[$];
    int fails = 0;
    int checks_done = 0;
    bus_node_setup #(.FLASH_HALF(4)) i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .switchTens, .switchOnes, .rateSwitch, .motorSupplyOk, .moveDone, .encoderPos,
        .moveTarget, .moveGo, .nodeAddr, .bitRate, .heartbeatEn, .ledGreen, .ledRed, .ledYellow);
    motion_core_model i_core (.ref_clk, .rst, .moveGo, .moveTarget, .legDelay, .encSkew, .moveDone, .encoderPos);
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // record every leg handed to the motion core
    always @(posedge ref_clk) begin
        if (moveGo === 1'b1) legs.push_back(moveTarget);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bad_wait;
        fails++;
        $display("[ERR] %0t wait limit reached", $time);
        conclude();
    endtask
    // one apb transfer; result left in rdv and errv
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) bad_wait();
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset_values;
        check(32'(nodeAddr), 32'd63);
        check(32'(heartbeatEn), 32'h0);
        apb(1'b0, OFF_FEATURES, 32'h0);
        check(rdv, 32'h0000_0742);
        apb(1'b0, 8'h24, 32'h0);
        check(32'(errv), 32'h1);
        apb(1'b1, OFF_CTRL, 32'hd);
        @(posedge ref_clk);
        check(32'(heartbeatEn), 32'h1);
    endtask
    task automatic addr_select;
        switchTens <= 4'd1;
        switchOnes <= 4'd2;
        apb(1'b1, OFF_NODE_ADDR, 32'd5);
        check(32'(errv), 32'h1);
        @(posedge ref_clk);
        check(32'(nodeAddr), 32'd12);
        switchTens <= 4'd6;
        switchOnes <= 4'd4;
        apb(1'b1, OFF_NODE_ADDR, 32'd5);
        check(32'(errv), 32'h0);
        // the bus value passes its own register before the output one
        repeat (2) @(posedge ref_clk);
        check(32'(nodeAddr), 32'd5);
    endtask
    task automatic rate_select;
        logic [9:0] exp[4] = '{RATE_125, RATE_500, RATE_250, RATE_125};
        for (int i = 0; i < 4; i++) begin
            rateSwitch <= 2'(i);
            repeat (3) @(posedge ref_clk);
            check(32'(bitRate), 32'(exp[i]));
        end
        // both switches on: the bus-written rate takes over
        apb(1'b1, OFF_RATE, 32'(RATE_250));
        repeat (2) @(posedge ref_clk);
        check(32'(bitRate), 32'(RATE_250));
    endtask
    task automatic led_states;
        logic [4:0] nets[7] = '{5'h00, 5'h03, 5'h01, 5'h07, 5'h0b, 5'h13, 5'h03};
        logic [4:0] exps[7] = '{5'h15, 5'h06, 5'h17, 5'h1d, 5'h09, 5'h0f, 5'h17};
        logic [4:0] seen;
        motorSupplyOk <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(32'(ledYellow), 32'h0);
        motorSupplyOk <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, OFF_CTRL, (i == 6) ? 32'h5 : 32'hd);
            apb(1'b1, OFF_NET, 32'(nets[i]));
            repeat (3) @(posedge ref_clk);
            seen = 5'h00;
            // collect which colour levels show over two flash periods
            repeat (16) begin
                @(posedge ref_clk);
                seen |= {ledRed === ledGreen, ledRed === 1'b1, ledRed === 1'b0, ledGreen === 1'b1, ledGreen === 1'b0};
            end
            check(32'(seen), 32'(exps[i]));
        end
        check(32'(ledYellow), 32'h1);
    endtask
    // one positioning run; legs and error flag compared at the end
    task automatic move(input logic lp, input logic [31:0] act, tgt, input int nLeg, input logic [31:0] skew,
        input logic [3:0] dly);
        int n;
        encSkew <= skew;
        legDelay <= dly;
        apb(1'b1, OFF_ACTUAL, act);
        apb(1'b1, OFF_TARGET, tgt);
        legs.delete();
        apb(1'b1, OFF_CTRL, {28'h0, 2'b11, 1'b1, lp});
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (rdv[STAT_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) bad_wait();
        check(32'(legs.size()), 32'(nLeg));
        check(legs[legs.size() - 1], tgt);
        if (nLeg == 2) check(legs[0], tgt - 32'(LOOP_OVERSHOOT));
        check(32'(rdv[STAT_ERROR_BIT]), 32'(skew != 32'h0));
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        switchTens = 4'd9;
        switchOnes = 4'd9;
        rateSwitch = 2'b00;
        motorSupplyOk = 1'b1;
        legDelay = 4'h2;
        encSkew = 32'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_values();
        addr_select();
        rate_select();
        led_states();
        move(1'b1, 32'd1000, 32'd2000, 1, 32'h0, 4'h2);
        move(1'b1, 32'd2000, 32'd1500, 2, 32'h0, 4'h9);
        move(1'b1, 32'd1500, 32'd1800, 1, 32'h3, 4'h2);
        move(1'b0, 32'd1800, 32'd1200, 1, 32'h0, 4'h2);
        move(1'b0, 32'd1200, 32'd900, 2, 32'h0, 4'h9);
        move(1'b0, 32'd900, 32'd1000, 1, 32'h0, 4'h2);
        conclude();
    end
endmodule // bus_node_setup_tb
